//--- rtl/ioexp_top.sv
// Top of the 24-bit port expander: serial target, APB registers, alert.
//
// What this block does
// [R1] 24 pins in three 8-bit banks, each with direction, input, output, polarity.
// [R2] After power-up every pin is an input.
// [R3] Each pin's direction follows the direction bit the controller writes.
// [R4] Input values live in the input register, output values in output.
// [R5] A set polarity bit inverts that pin's reported input value.
// [R6] Every register, including direction, output and polarity, reads back.
// [R7] Power-up reset loads all register defaults and idles the link engine.
// [R8] The low reset pin does the same defaulting and link reinitialisation.
// [R9] Alert output pulls active while any input differs from its input register.
// [R10] The link target address takes its low bit from the strap pin.
// [R11] Output pins are driven push-pull, both high and low.
// [R12] Output register drives a pin only while it is an output.
// [R13] Alert releases once input register and pins agree again.
`timescale 1ns/100ps
module ioexp_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // Serial link, open drain data
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Device pins
   input wire logic reset_pin_n,
   input wire logic addr_strap,
   output logic alert_o,
   output logic alert_oe,
   // Port pins; bit 0 is expander_pin_first, bit 23 expander_pin_last
   input wire logic [23:0] expander_pin_i,
   output logic [23:0] expander_pin_o,
   output logic [23:0] expander_pin_oe
);
   localparam int NB = ioexp_pkg::BANKS;

   // ------------------------------------------------------------
   // Shared decoding
   // ------------------------------------------------------------
   function automatic logic [7:0] reg_byte(input ioexp_pkg::ioexp_bank_s [NB-1:0] v,
                                           input logic [3:0] idx);
      logic [7:0] r;
      r = 8'h00;
      if (idx[1:0] != ioexp_pkg::BANK_NONE) begin
         case (idx[3:2])
            ioexp_pkg::KIND_IN: r = v[idx[1:0]].in;
            ioexp_pkg::KIND_OUT: r = v[idx[1:0]].out;
            ioexp_pkg::KIND_POL: r = v[idx[1:0]].pol;
            default: r = v[idx[1:0]].dir;
         endcase
      end
      return r;
   endfunction

   function automatic logic [3:0] next_idx(input logic [3:0] idx);
      if (idx[1:0] >= ioexp_pkg::BANK_LAST) begin
         return {2'(idx[3:2] + 2'h1), 2'h0};
      end
      return 4'(idx + 4'h1);
   endfunction

   function automatic logic apb_hit(input logic [7:0] a);
      if (a[1:0] != 2'h0) begin
         return 1'b0;
      end
      if (a < ioexp_pkg::OFS_BANK_END) begin
         return a[3:2] != ioexp_pkg::BANK_NONE;
      end
      return a == ioexp_pkg::OFS_IRQ_STS || a == ioexp_pkg::OFS_IRQ_MASK ||
             a == ioexp_pkg::OFS_INFO;
   endfunction

   // ------------------------------------------------------------
   // Synchronisers and reset
   // ------------------------------------------------------------
   logic [27:0] sync_q;
   logic [23:0] pin_s;
   logic scl_s, sda_s, rst_pin_s, strap_s;
   logic [1:0] settle_r, settle_nxt;
   logic init;
   logic [6:0] my_addr;

   ioexp_sync #(.W(28)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({addr_strap, reset_pin_n, scl_i, sda_i, expander_pin_i}),
      .q(sync_q)
   );
   assign {strap_s, rst_pin_s, scl_s, sda_s, pin_s} = sync_q;

   // Pin reset holds everything at defaults; the settle count lets the
   // synchronised pins fill before the input snapshot is taken.
   always_comb begin
      settle_nxt = settle_r;
      if (!rst_pin_s) begin
         settle_nxt = 2'h0; // R8
      end else if (settle_r != ioexp_pkg::SETTLE_CYC) begin
         settle_nxt = 2'(settle_r + 2'h1);
      end
   end
   assign init = !rst_pin_s || settle_r != ioexp_pkg::SETTLE_CYC; // R7 R8
   assign my_addr = {ioexp_pkg::LINK_ADDR_BASE[6:1], strap_s}; // R10

   // ------------------------------------------------------------
   // Port banks
   // ------------------------------------------------------------
   ioexp_pkg::ioexp_bank_s [NB-1:0] view;
   ioexp_pkg::ioexp_wr_s [NB-1:0] bank_wr;
   logic [NB-1:0] refresh, diff;
   ioexp_pkg::ioexp_wr_s apb_wr, link_wr;
   logic [1:0] apb_bank, link_bank;
   logic [NB-1:0] apb_ref, link_ref;

   for (genvar b = 0; b < NB; b++) begin : g_bank
      // APB wins a same-cycle collision; the link write is then dropped.
      assign bank_wr[b] = (apb_wr.en && apb_bank == 2'(b)) ? apb_wr :
                          (link_wr.en && link_bank == 2'(b)) ? link_wr : '0;
      assign refresh[b] = apb_ref[b] | link_ref[b];
      ioexp_bank u_bank ( // R1
         .pclk(pclk),
         .presetn(presetn),
         .init(init),
         .pin_s(pin_s[b*8 +: 8]),
         .wr(bank_wr[b]),
         .refresh(refresh[b]),
         .view(view[b]),
         .pin_o(expander_pin_o[b*8 +: 8]),
         .pin_oe(expander_pin_oe[b*8 +: 8]),
         .diff(diff[b])
      );
   end

   // ------------------------------------------------------------
   // Serial link target
   // ------------------------------------------------------------
   ioexp_pkg::ioexp_link_e st_r, st_nxt, after_r, after_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [3:0] cnt_r, cnt_nxt, ptr_r, ptr_nxt;
   logic sda_oe_r, sda_oe_nxt;
   logic scl_d_r, sda_d_r;
   logic rise, fall, start, stop, load;
   logic [7:0] rbyte;

   assign rise = scl_s && !scl_d_r;
   assign fall = !scl_s && scl_d_r;
   assign start = scl_s && scl_d_r && sda_d_r && !sda_s;
   assign stop = scl_s && scl_d_r && !sda_d_r && sda_s;
   assign rbyte = reg_byte(view, ptr_r);

   always_comb begin
      st_nxt = st_r;
      after_nxt = after_r;
      sh_nxt = sh_r;
      cnt_nxt = cnt_r;
      ptr_nxt = ptr_r;
      sda_oe_nxt = sda_oe_r;
      link_wr = '0;
      link_bank = ptr_r[1:0];
      link_ref = '0;
      load = 1'b0;
      if (init) begin
         st_nxt = ioexp_pkg::LK_IDLE; // R7 R8
         sda_oe_nxt = 1'b0;
         ptr_nxt = 4'h0;
      end else if (start) begin
         st_nxt = ioexp_pkg::LK_ADDR;
         cnt_nxt = 4'h0;
         sda_oe_nxt = 1'b0;
      end else if (stop) begin
         st_nxt = ioexp_pkg::LK_IDLE;
         sda_oe_nxt = 1'b0;
      end else begin
         case (st_r)
            ioexp_pkg::LK_ADDR, ioexp_pkg::LK_CMD, ioexp_pkg::LK_WDATA: begin
               if (rise) begin
                  sh_nxt = {sh_r[6:0], sda_s};
                  cnt_nxt = 4'(cnt_r + 4'h1);
                  if (cnt_r == ioexp_pkg::LAST_BIT) begin
                     cnt_nxt = 4'h0;
                     st_nxt = ioexp_pkg::LK_ACK1;
                     after_nxt = ioexp_pkg::LK_WDATA;
                     if (st_r == ioexp_pkg::LK_ADDR) begin
                        if (sh_nxt[7:1] != my_addr) begin
                           st_nxt = ioexp_pkg::LK_IDLE; // R10
                        end else if (sh_nxt[0]) begin
                           after_nxt = ioexp_pkg::LK_RDATA;
                        end else begin
                           after_nxt = ioexp_pkg::LK_CMD;
                        end
                     end else if (st_r == ioexp_pkg::LK_CMD) begin
                        ptr_nxt = sh_nxt[3:0];
                     end else begin
                        link_wr = '{en: 1'b1, kind: ptr_r[3:2], data: sh_nxt}; // R3 R4
                        ptr_nxt = next_idx(ptr_r);
                     end
                  end
               end
            end
            ioexp_pkg::LK_ACK1: begin
               if (fall) begin
                  sda_oe_nxt = 1'b1;
                  st_nxt = ioexp_pkg::LK_ACK2;
               end
            end
            ioexp_pkg::LK_ACK2: begin
               if (fall) begin
                  sda_oe_nxt = 1'b0;
                  st_nxt = after_r;
                  load = (after_r == ioexp_pkg::LK_RDATA);
               end
            end
            ioexp_pkg::LK_RDATA: begin
               if (fall) begin
                  if (cnt_r == ioexp_pkg::BYTE_BITS) begin
                     sda_oe_nxt = 1'b0;
                     st_nxt = ioexp_pkg::LK_MACK;
                  end else begin
                     sh_nxt = {sh_r[6:0], 1'b0};
                     sda_oe_nxt = !sh_nxt[7];
                     cnt_nxt = 4'(cnt_r + 4'h1);
                  end
               end
            end
            ioexp_pkg::LK_MACK: begin
               if (rise) begin
                  st_nxt = sda_s ? ioexp_pkg::LK_IDLE : ioexp_pkg::LK_MNEXT;
               end
            end
            ioexp_pkg::LK_MNEXT: begin
               if (fall) begin
                  st_nxt = ioexp_pkg::LK_RDATA;
                  load = 1'b1;
               end
            end
            default: ;
         endcase
         // Loading a byte for the controller counts as a read of that register.
         if (load) begin
            sh_nxt = rbyte; // R6
            sda_oe_nxt = !rbyte[7];
            cnt_nxt = 4'h1;
            ptr_nxt = next_idx(ptr_r);
            if (ptr_r[3:2] == ioexp_pkg::KIND_IN && ptr_r[1:0] != ioexp_pkg::BANK_NONE) begin
               link_ref[ptr_r[1:0]] = 1'b1; // R13
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ioexp_pkg::LK_IDLE;
         after_r <= ioexp_pkg::LK_IDLE;
         sh_r <= 8'h00;
         cnt_r <= 4'h0;
         ptr_r <= 4'h0;
         sda_oe_r <= 1'b0;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         settle_r <= 2'h0;
      end else begin
         st_r <= st_nxt;
         after_r <= after_nxt;
         sh_r <= sh_nxt;
         cnt_r <= cnt_nxt;
         ptr_r <= ptr_nxt;
         sda_oe_r <= sda_oe_nxt;
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         settle_r <= settle_nxt;
      end
   end

   // ------------------------------------------------------------
   // APB slave, interrupt status and alert
   // ------------------------------------------------------------
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   localparam int IRQ_W_T = ioexp_pkg::IRQ_W;
   logic [IRQ_W_T-1:0] sts_r, sts_nxt, mask_r, mask_nxt, ev;
   logic irq_r, irq_nxt, alert_r, alert_nxt;
   logic apb_done, apb_ok;
   logic [31:0] rd_val;

   assign apb_ok = apb_hit(paddr);
   assign apb_done = psel && penable && pready_r;
   assign apb_bank = paddr[3:2];

   always_comb begin
      rd_val = 32'h0000_0000;
      if (paddr < ioexp_pkg::OFS_BANK_END) begin
         rd_val = {24'h00_0000, reg_byte(view, paddr[5:2])}; // R6
      end else if (paddr == ioexp_pkg::OFS_IRQ_STS) begin
         rd_val = {29'h0000_0000, sts_r};
      end else if (paddr == ioexp_pkg::OFS_IRQ_MASK) begin
         rd_val = {29'h0000_0000, mask_r};
      end else if (paddr == ioexp_pkg::OFS_INFO) begin
         rd_val = {23'h00_0000, st_r != ioexp_pkg::LK_IDLE, strap_s, my_addr};
      end
   end

   always_comb begin
      pready_nxt = psel && penable && !pready_r;
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      if (pready_nxt) begin
         prdata_nxt = (apb_ok && !pwrite) ? rd_val : 32'h0000_0000;
         pslverr_nxt = !apb_ok;
      end
      apb_wr = '0;
      apb_ref = '0;
      mask_nxt = mask_r;
      if (apb_done && apb_ok && !init) begin
         if (pwrite && paddr < ioexp_pkg::OFS_BANK_END) begin
            apb_wr = '{en: 1'b1, kind: paddr[5:4], data: pwdata[7:0]}; // R3 R4
         end
         if (!pwrite && paddr < ioexp_pkg::OFS_BANK_END &&
             paddr[5:4] == ioexp_pkg::KIND_IN) begin
            apb_ref[paddr[3:2]] = 1'b1; // R13
         end
         if (pwrite && paddr == ioexp_pkg::OFS_IRQ_MASK) begin
            mask_nxt = pwdata[IRQ_W_T-1:0];
         end
      end
      alert_nxt = !init && (|diff); // R9 R13
      ev = '0;
      ev[ioexp_pkg::EV_ALERT] = alert_nxt && !alert_r;
      ev[ioexp_pkg::EV_LINK_WR] = link_wr.en;
      ev[ioexp_pkg::EV_LINK_RD] = load;
      sts_nxt = sts_r;
      // Only the bits handed out by the read are cleared; an event that lands
      // between data capture and the pready edge would otherwise be lost.
      if (apb_done && !pwrite && paddr == ioexp_pkg::OFS_IRQ_STS) begin
         sts_nxt = sts_r & ~prdata_r[IRQ_W_T-1:0];
      end
      // A new event in the clearing cycle is kept.
      sts_nxt = sts_nxt | ev;
      if (init) begin
         sts_nxt = '0; // R8
         mask_nxt = ioexp_pkg::RST_IRQ_MASK;
      end
      irq_nxt = |(sts_nxt & mask_nxt);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         sts_r <= '0;
         mask_r <= ioexp_pkg::RST_IRQ_MASK;
         irq_r <= 1'b0;
         alert_r <= 1'b0;
      end else begin
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r <= prdata_nxt;
         sts_r <= sts_nxt;
         mask_r <= mask_nxt;
         irq_r <= irq_nxt;
         alert_r <= alert_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;
   // Open-drain outputs only ever pull low; the enable carries the level.
   assign sda_o = 1'b0;
   assign sda_oe = sda_oe_r;
   assign alert_o = 1'b0;
   assign alert_oe = alert_r; // R9
endmodule

//--- rtl/ioexp_pkg.sv
// Shared constants, layouts and state types of the 24-bit port expander.
package ioexp_pkg;

   // ------------------------------------------------------------
   // Port banks
   // ------------------------------------------------------------
   localparam int BANKS = 3;
   localparam int BANK_W = 8;
   localparam logic [1:0] KIND_IN = 2'h0;
   localparam logic [1:0] KIND_OUT = 2'h1;
   localparam logic [1:0] KIND_POL = 2'h2;
   localparam logic [1:0] KIND_DIR = 2'h3;
   localparam logic [1:0] BANK_NONE = 2'h3;
   localparam logic [1:0] BANK_LAST = 2'h2;
   localparam logic [7:0] RST_OUT = 8'hFF;
   localparam logic [7:0] RST_POL = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hFF;

   // ------------------------------------------------------------
   // Register map: bank registers sit at {kind, bank, 2'b00}
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_BANK_END = 8'h40;
   localparam logic [7:0] OFS_IRQ_STS = 8'h40;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
   localparam logic [7:0] OFS_INFO = 8'h48;
   localparam int IRQ_W = 3;
   localparam int EV_ALERT = 0;
   localparam int EV_LINK_WR = 1;
   localparam int EV_LINK_RD = 2;
   localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;

   // ------------------------------------------------------------
   // Serial link and reset timing
   // ------------------------------------------------------------
   localparam logic [6:0] LINK_ADDR_BASE = 7'h22;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [1:0] SETTLE_CYC = 2'h3;

   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] pol;
      logic [7:0] out;
      logic [7:0] in;
   } ioexp_bank_s;

   typedef struct packed {
      logic en;
      logic [1:0] kind;
      logic [7:0] data;
   } ioexp_wr_s;

   typedef enum {
      LK_IDLE, LK_ADDR, LK_CMD, LK_WDATA, LK_ACK1, LK_ACK2, LK_RDATA, LK_MACK, LK_MNEXT
   } ioexp_link_e;

endpackage

//--- rtl/ioexp_sync.sv
// Two-stage synchroniser for levels arriving from outside the pclk domain.
`timescale 1ns/100ps
module ioexp_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule

//--- rtl/ioexp_bank.sv
// One 8-bit port bank: direction, output, polarity and input snapshot.
`timescale 1ns/100ps
module ioexp_bank (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic init,
   // Pins, already synchronised
   input wire logic [7:0] pin_s,
   // Register access
   input wire ioexp_pkg::ioexp_wr_s wr,
   input wire logic refresh,
   output ioexp_pkg::ioexp_bank_s view,
   // Pin drive and change flag
   output logic [7:0] pin_o,
   output logic [7:0] pin_oe,
   output logic diff
);
   logic [7:0] out_r, out_nxt;
   logic [7:0] pol_r, pol_nxt;
   logic [7:0] dir_r, dir_nxt;
   logic [7:0] lat_r, lat_nxt;
   logic [7:0] oe_r, oe_nxt;

   always_comb begin
      out_nxt = out_r;
      pol_nxt = pol_r;
      dir_nxt = dir_r;
      lat_nxt = lat_r;
      if (init) begin
         out_nxt = ioexp_pkg::RST_OUT; // R7 R8
         pol_nxt = ioexp_pkg::RST_POL;
         dir_nxt = ioexp_pkg::RST_DIR; // R2
         lat_nxt = pin_s;
      end else begin
         if (wr.en) begin
            case (wr.kind)
               ioexp_pkg::KIND_OUT: out_nxt = wr.data; // R4
               ioexp_pkg::KIND_POL: pol_nxt = wr.data;
               ioexp_pkg::KIND_DIR: dir_nxt = wr.data; // R3
               default: ;
            endcase
         end
         // A read of the input register re-arms the change detector.
         if (refresh) begin
            lat_nxt = pin_s; // R4 R13
         end
      end
      // A direction bit of one means input; the pin is then left undriven.
      oe_nxt = ~dir_nxt; // R11 R12
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_r <= ioexp_pkg::RST_OUT;
         pol_r <= ioexp_pkg::RST_POL;
         dir_r <= ioexp_pkg::RST_DIR;
         lat_r <= 8'h00;
         oe_r <= 8'h00;
      end else begin
         out_r <= out_nxt;
         pol_r <= pol_nxt;
         dir_r <= dir_nxt;
         lat_r <= lat_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign view.dir = dir_r; // R6
   assign view.pol = pol_r;
   assign view.out = out_r;
   assign view.in = lat_r ^ pol_r; // R5
   assign pin_o = out_r; // R11
   assign pin_oe = oe_r;
   assign diff = |((pin_s ^ lat_r) & dir_r); // R9
endmodule

//--- test/ioexp_sva.sv
// Concurrent checks on the expander top ports.
`timescale 1ns/100ps
module ioexp_sva (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register bus
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Device pins
   input wire logic reset_pin_n,
   input wire logic alert_o,
   input wire logic alert_oe,
   input wire logic [23:0] expander_pin_oe
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic acc;
   assign acc = psel && penable && pready;
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   a_unaligned_err: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access accepted");
   a_hole_err: assert property (acc && paddr[3:2] == 2'h3 && paddr < 8'h40 |-> pslverr)
      else $error("access to bank hole accepted");
   a_mapped_ok: assert property (acc && paddr < 8'h4C && paddr[3:2] != 2'h3
      && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped register refused");
   a_info_addr: assert property (acc && !pwrite && paddr == 8'h48
      |-> prdata[6:0] == {6'h11, prdata[7]})
      else $error("target address does not follow strap");
   a_alert_drain: assert property (alert_o == 1'b0)
      else $error("alert line driven high");
   a_boot_inputs: assert property ($rose(presetn) |-> expander_pin_oe == 24'h000000)
      else $error("pin driven right after reset");
   a_pin_reset: assert property (!reset_pin_n [*8] |-> expander_pin_oe == 24'h000000)
      else $error("pin driven while reset pin low");
   a_alert_reset: assert property (!reset_pin_n [*4] |-> !alert_oe)
      else $error("alert active while reset pin low");
endmodule

bind ioexp_top ioexp_sva u_sva (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .reset_pin_n(reset_pin_n), .alert_o(alert_o), .alert_oe(alert_oe),
   .expander_pin_oe(expander_pin_oe));

//--- test/ioexp_i2c_host.sv
// Serial bus controller model driving the link clock and open-drain data.
`timescale 1ns/100ps
module ioexp_i2c_host (
   // Link
   output logic scl,
   output logic sda_oe,
   input wire logic sda
);
   // Clock idles high and data stays released between frames.
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic bit_io(input logic v, output logic r);
      sda_oe = ~v;
      #31.25 scl = 1'b1;
      #31.25 r = sda;
      #31.25 scl = 1'b0;
      #31.25;
   endtask
   task automatic start();
      sda_oe = 1'b0;
      #31.25 scl = 1'b1;
      #31.25 sda_oe = 1'b1;
      #31.25 scl = 1'b0;
      #31.25;
   endtask
   task automatic stop();
      sda_oe = 1'b1;
      #31.25 scl = 1'b1;
      #31.25 sda_oe = 1'b0;
      #31.25;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(nack, r);
   endtask
endmodule

//--- test/ioexp_tb_top.sv
// Self-checking bench of the 24-bit port expander.
`timescale 1ns/100ps
module ioexp_tb_top;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic x;} ioexp_row_s;
   logic pclk, presetn, psel, penable, pwrite, reset_pin_n, addr_strap, pready, pslverr, irq;
   logic scl, sda, sda_o, sda_oe, h_oe, alert_o, alert_oe, err, ack;
   logic [7:0] paddr, b;
   logic [31:0] pwdata, prdata, rd;
   logic [23:0] ext, pin_o, pin_oe, pin_lvl;
   int n_errors = 0;
   int num_checks = 0;
   ioexp_row_s rows [10] = '{'{8'h30, 32'h0F, 32'h0F, 1'b0}, '{8'h34, 32'h00, 32'h00, 1'b0},
      '{8'h38, 32'hA5, 32'hA5, 1'b0}, '{8'h10, 32'h3C, 32'h3C, 1'b0},
      '{8'h14, 32'h5A, 32'h5A, 1'b0}, '{8'h18, 32'hC3, 32'hC3, 1'b0},
      '{8'h20, 32'h05, 32'h05, 1'b0}, '{8'h0C, 32'h77, 32'h00, 1'b1},
      '{8'h02, 32'h11, 32'h00, 1'b1}, '{8'h4C, 32'h01, 32'h00, 1'b1}};
   // SDA has a pull-up; an input pin shows what the outside world drives.
   assign sda = !(h_oe || sda_oe);
   assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext);
   ioexp_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .reset_pin_n(reset_pin_n), .addr_strap(addr_strap), .alert_o(alert_o),
      .alert_oe(alert_oe), .expander_pin_i(pin_lvl), .expander_pin_o(pin_o),
      .expander_pin_oe(pin_oe));
   ioexp_i2c_host host (.scl(scl), .sda_oe(h_oe), .sda(sda));
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         n_errors++;
         summarize();
      end
   endtask
   task automatic wait_alert(input logic v);
      int n;
      n = 0;
      while (alert_oe !== v && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk("alert_oe", {31'h0, alert_oe}, {31'h0, v});
      if (n >= 20) begin
         summarize();
      end
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (50000) @(posedge pclk);
      n_errors++;
      summarize();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      reset_pin_n = 1'b1;
      addr_strap = 1'b1;
      ext = 24'h000009;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("pin_oe", {8'h00, pin_oe}, 32'h0);
      for (int i = 0; i < 3; i++) begin
         apb(8'h30 + 8'(4 * i), 1'b0, 32'h0);
         chk("dir", rd, 32'hFF);
         apb(8'h10 + 8'(4 * i), 1'b0, 32'h0);
         chk("out", rd, 32'hFF);
         apb(8'h20 + 8'(4 * i), 1'b0, 32'h0);
         chk("pol", rd, 32'h0);
      end
      $display("test defaults done");
      foreach (rows[i]) begin
         apb(rows[i].a, 1'b1, rows[i].d);
         chk("wr_err", {31'h0, err}, {31'h0, rows[i].x});
         apb(rows[i].a, 1'b0, 32'h0);
         chk("rd_data", rd, rows[i].e);
      end
      chk("pin_oe", {8'h00, pin_oe}, 32'h005AFFF0);
      chk("pin_o", {8'h00, pin_o}, 32'h00C35A3C);
      repeat (2) apb(8'h00, 1'b0, 32'h0);
      chk("in0", rd, 32'h3C);
      repeat (2) apb(8'h04, 1'b0, 32'h0);
      chk("in1", rd, 32'h5A);
      $display("test registers done");
      apb(8'h40, 1'b0, 32'h0);
      wait_alert(1'b0);
      ext <= 24'h00000B;
      wait_alert(1'b1);
      chk("irq", {31'h0, irq}, 32'h0);
      apb(8'h44, 1'b1, 32'h1);
      repeat (3) @(posedge pclk);
      chk("irq", {31'h0, irq}, 32'h1);
      apb(8'h40, 1'b0, 32'h0);
      chk("sts", rd & 32'h1, 32'h1);
      repeat (3) @(posedge pclk);
      chk("irq", {31'h0, irq}, 32'h0);
      apb(8'h00, 1'b0, 32'h0);
      wait_alert(1'b0);
      $display("test alert done");
      reset_pin_n <= 1'b0;
      repeat (10) @(posedge pclk);
      reset_pin_n <= 1'b1;
      repeat (10) @(posedge pclk);
      chk("pin_oe", {8'h00, pin_oe}, 32'h0);
      apb(8'h30, 1'b0, 32'h0);
      chk("dir", rd, 32'hFF);
      apb(8'h44, 1'b0, 32'h0);
      chk("mask", rd, 32'h0);
      $display("test reset pin done");
      apb(8'h48, 1'b0, 32'h0);
      chk("info", rd, 32'hA3);
      host.start();
      host.wbyte(8'h44, ack);
      host.stop();
      chk("nack", {31'h0, ack}, 32'h0);
      host.start();
      host.wbyte(8'h46, ack);
      chk("ack", {31'h0, ack}, 32'h1);
      host.wbyte(8'h0D, ack);
      host.wbyte(8'h81, ack);
      host.wbyte(8'h42, ack);
      host.stop();
      apb(8'h34, 1'b0, 32'h0);
      chk("dir1", rd, 32'h81);
      apb(8'h38, 1'b0, 32'h0);
      chk("dir2", rd, 32'h42);
      host.start();
      host.wbyte(8'h46, ack);
      host.wbyte(8'h0D, ack);
      host.start();
      host.wbyte(8'h47, ack);
      host.rbyte(1'b0, b);
      chk("link_rd", {24'h0, b}, 32'h81);
      host.rbyte(1'b1, b);
      host.stop();
      chk("link_rd2", {24'h0, b}, 32'h42);
      $display("test link done");
      summarize();
   end
endmodule
